// ---- qrd_top.sv ----
// Command interpreter core: delimiter forcing, display refresh policy, header stripping
//
// Summary of operation
// - Removing an alias not in the list reports execution error 271.
// - Force-delimiter command emits end delimiter for the pending query response.
// - Force-delimiter with nothing pending does nothing and reports no error.
// - Policy ON: refresh the panel after each successful set command.
// - Policy OFF: refresh on device clear or selected device clear at either port.
// - Policy OFF: refresh when a set or query command is malformed.
// - Policy OFF: refresh after success only if its input buffer is empty.
// - Policy NEVER: suppress all refreshes except debug and screen text writes.
// - Entering NEVER removes axis labels, blanks menu, freezes knob readouts.
// - Leaving NEVER restores axis labels and refreshes the whole panel.
// - Display policy is OFF after power-up.
// - Panel controls fully functional with readouts when policy is ON or OFF.
// - Header switch OFF strips headers and links from query responses.
// - Header switch is ON after power-up.
// - Settings-dump responses always carry headers and links.
// - Serial verbose mode ignores header switch on serial responses.
// - Header switch OFF strips only headers of self-test and setting list queries.
// - Queries of both settings return the currently selected argument.
// - Device clear at the looping port ends a recursive alias loop.
`timescale 1ns/1ns

module qrd_top
  import qrd_pkg::*;
(
  input  wire logic        CLK,         // 250 MHz clock
  input  wire logic        RESETN,      // Asynchronous reset, active low
  input  wire logic        PSEL,        // APB select
  input  wire logic        PENABLE,     // APB enable
  input  wire logic        PWRITE,      // APB direction
  input  wire logic [7:0]  PADDR,       // APB byte address
  input  wire logic [31:0] PWDATA,      // APB write data
  output logic      [31:0] PRDATA,      // APB read data
  output logic             PREADY,      // APB ready
  output logic             PSLVERR,     // APB error on unmapped address
  input  wire logic        TEXT_WRITE,  // Debug or screen-text write pulse
  output logic             REFRESH,     // Panel refresh pulse
  output logic             TEXT_SHOW,   // Pass-through of explicit text data
  output logic             EOI_OUT,     // End delimiter pulse
  output logic             LABELS_ON,   // Axis labels shown
  output logic             MENU_BLANK,  // Blank major menu shown
  output logic             KNOB_TRACK,  // Knob readouts track parameters
  output logic             ERR_EVENT    // Execution error pulse
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    qrd_policy_t policy;
    logic        header_on;
    logic        verbose;
    logic        pending;
    logic        pending_port;
    logic        loop_active;
    logic        loop_port;
    logic        labels;
    logic        blank;
    logic        knob_track;
    logic        refresh;
    logic        text_show;
    logic        eoi;
    logic        err;
    logic        eoi_seen;
    logic [8:0]  event_code;
    logic [1:0]  rsp_fmt;
    logic [ALIAS_SLOTS-1:0]       alias_valid;
    logic [ALIAS_SLOTS-1:0][7:0]  alias_key;
    logic [31:0] prdata;
  } qrd_state_t;

  qrd_state_t s_reg;
  qrd_state_t s_next;

  // Returns one-hot match of a key against the alias table
  function automatic logic [ALIAS_SLOTS-1:0] alias_hit(
    input logic [ALIAS_SLOTS-1:0]      valid,
    input logic [ALIAS_SLOTS-1:0][7:0] keys,
    input logic [7:0]                  key
  );
    logic [ALIAS_SLOTS-1:0] hit;
    hit = '0;
    for (int i = 0; i < ALIAS_SLOTS; i++) begin
      hit[i] = valid[i] && (keys[i] == key);
    end
    return hit;
  endfunction

  // Entry side effects when the policy changes
  function automatic logic [2:0] policy_view(input qrd_policy_t p);
    // {labels, blank menu, knob tracking}
    return (p == POL_NEVER) ? 3'b010 : 3'b101;
  endfunction

  logic                   wr_acc;
  logic                   rd_acc;
  logic                   addr_ok;
  qrd_op_t                op;
  logic [3:0]             arg;
  logic                   port;
  logic                   buf_empty;
  logic                   bad_cmd;
  logic [7:0]             akey;
  logic [ALIAS_SLOTS-1:0] hit;
  logic [ALIAS_SLOTS-1:0] free_slot;
  logic                   ref_req;
  logic                   cmd_ok;
  qrd_policy_t            new_pol;

  assign wr_acc  = PSEL && PENABLE && PWRITE;
  assign rd_acc  = PSEL && PENABLE && !PWRITE;
  assign addr_ok = (PADDR == ADDR_CMD) || (PADDR == ADDR_CTRL) || (PADDR == ADDR_STATUS) ||
                   (PADDR == ADDR_EVENT) || (PADDR == ADDR_ALIAS) || (PADDR == ADDR_RESPONSE);

  assign op        = qrd_op_t'(PWDATA[CMD_OP_LSB +: 4]);
  assign arg       = PWDATA[CMD_ARG_LSB +: 4];
  assign port      = PWDATA[CMD_PORT_BIT];
  assign buf_empty = PWDATA[CMD_EMPTY_BIT];
  assign bad_cmd   = PWDATA[CMD_BAD_BIT];
  assign akey      = PWDATA[CMD_ALIAS_LSB +: 8];

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    s_next           = s_reg;
    s_next.refresh   = 1'b0;
    s_next.eoi       = 1'b0;
    s_next.err       = 1'b0;
    s_next.text_show = 1'b0;
    hit              = alias_hit(s_reg.alias_valid, s_reg.alias_key, akey);
    free_slot        = ~s_reg.alias_valid & (s_reg.alias_valid + {{(ALIAS_SLOTS-1){1'b0}}, 1'b1});
    ref_req          = 1'b0;
    cmd_ok           = 1'b0;
    new_pol          = s_reg.policy;

    // Explicit text writes bypass the policy
    if (TEXT_WRITE) begin
      s_next.text_show = 1'b1;
    end

    if (wr_acc && PADDR == ADDR_CTRL) begin
      s_next.verbose = PWDATA[CTRL_VERBOSE_BIT];
    end

    if (wr_acc && PADDR == ADDR_CMD) begin
      case (op)
        OP_SET, OP_QUERY, OP_LIST_QUERY, OP_SET_DUMP: begin
          if (bad_cmd) begin
            ref_req = (s_reg.policy == POL_OFF);
          end else begin
            cmd_ok = 1'b1;
            if (op != OP_SET) begin
              s_next.pending      = 1'b1;
              s_next.pending_port = port;
              // Header and link presence for this response
              if (op == OP_SET_DUMP || (port && s_reg.verbose) || s_reg.header_on) begin
                s_next.rsp_fmt = 2'b11;
              end else if (op == OP_LIST_QUERY) begin
                s_next.rsp_fmt = 2'b10;
              end else begin
                s_next.rsp_fmt = 2'b00;
              end
            end
          end
        end
        OP_FORCE_EOI: begin
          cmd_ok = 1'b1;
          if (s_reg.pending) begin
            s_next.eoi      = 1'b1;
            s_next.eoi_seen = 1'b1;
            s_next.pending  = 1'b0;
          end
          // Nothing pending: no action, no error
        end
        OP_RSP_DONE: begin
          s_next.pending = 1'b0;
        end
        OP_POLICY: begin
          cmd_ok = 1'b1;
          case (arg[1:0])
            2'b00:   new_pol = POL_OFF;
            2'b01:   new_pol = POL_ON;
            default: new_pol = POL_NEVER;
          endcase
          s_next.policy = new_pol;
          {s_next.labels, s_next.blank, s_next.knob_track} = policy_view(new_pol);
          if (s_reg.policy == POL_NEVER && new_pol != POL_NEVER) begin
            s_next.refresh = 1'b1;
          end
        end
        OP_HEADER: begin
          cmd_ok           = 1'b1;
          s_next.header_on = arg[0];
        end
        OP_ALIAS_DEF: begin
          cmd_ok = 1'b1;
          if (hit == '0 && free_slot != '0) begin
            for (int i = 0; i < ALIAS_SLOTS; i++) begin
              if (free_slot[i]) begin
                s_next.alias_valid[i] = 1'b1;
                s_next.alias_key[i]   = akey;
              end
            end
          end
        end
        OP_ALIAS_DEL: begin
          if (arg[0]) begin
            s_next.alias_valid = '0;
          end else if (hit == '0) begin
            s_next.err        = 1'b1;
            s_next.event_code = EVT_UNDEFINED_ALIAS;
          end else begin
            s_next.alias_valid = s_reg.alias_valid & ~hit;
          end
        end
        OP_DEV_CLEAR: begin
          ref_req        = (s_reg.policy == POL_OFF);
          s_next.pending = 1'b0;
          if (s_reg.loop_active && s_reg.loop_port == port) begin
            s_next.loop_active = 1'b0;
          end
        end
        OP_LOOP_START: begin
          s_next.loop_active = 1'b1;
          s_next.loop_port   = port;
        end
        default: begin
        end
      endcase

      // Policy evaluated once the command completes
      if (cmd_ok && op != OP_POLICY) begin
        case (s_reg.policy)
          POL_ON:  ref_req = (op == OP_SET);
          POL_OFF: ref_req = buf_empty && !s_reg.loop_active;
          default: ref_req = 1'b0;
        endcase
      end
      if (ref_req && s_reg.policy != POL_NEVER) begin
        s_next.refresh = 1'b1;
      end
    end

    if (rd_acc && PADDR == ADDR_EVENT) begin
      s_next.event_code = s_next.err ? EVT_UNDEFINED_ALIAS : '0;
    end
    if (rd_acc && PADDR == ADDR_STATUS && !s_next.eoi) begin
      s_next.eoi_seen = 1'b0;
    end

    // Read data is loaded in the setup phase so that it stands at the access edge
    s_next.prdata = '0;
    if (rd_acc) begin
      s_next.prdata = s_reg.prdata;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        ADDR_CTRL:   s_next.prdata[CTRL_VERBOSE_BIT] = s_reg.verbose;
        ADDR_STATUS: begin
          s_next.prdata[ST_POLICY_LSB +: 2] = s_reg.policy;
          s_next.prdata[ST_HEADER_BIT]      = s_reg.header_on;
          s_next.prdata[ST_PENDING_BIT]     = s_reg.pending;
          s_next.prdata[ST_LABELS_BIT]      = s_reg.labels;
          s_next.prdata[ST_BLANK_BIT]       = s_reg.blank;
          s_next.prdata[ST_KNOBTRK_BIT]     = s_reg.knob_track;
          s_next.prdata[ST_PANEL_BIT]       = s_reg.pending_port;
          s_next.prdata[ST_LOOP_BIT]        = s_reg.loop_active;
          s_next.prdata[ST_EOI_BIT]         = s_reg.eoi_seen;
        end
        ADDR_EVENT:    s_next.prdata[8:0] = s_reg.event_code;
        ADDR_ALIAS:    s_next.prdata[ALIAS_SLOTS-1:0] = s_reg.alias_valid;
        ADDR_RESPONSE: s_next.prdata[1:0] = s_reg.rsp_fmt;
        default:       s_next.prdata = '0;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_reg            <= '0;
      s_reg.policy     <= POLICY_RESET;
      s_reg.header_on  <= HEADER_RESET;
      s_reg.labels     <= 1'b1;
      s_reg.knob_track <= 1'b1;
      s_reg.rsp_fmt    <= 2'b11;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign PRDATA     = s_reg.prdata;
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL && PENABLE && !addr_ok;
  assign REFRESH    = s_reg.refresh;
  assign TEXT_SHOW  = s_reg.text_show;
  assign EOI_OUT    = s_reg.eoi;
  assign LABELS_ON  = s_reg.labels;
  assign MENU_BLANK = s_reg.blank;
  assign KNOB_TRACK = s_reg.knob_track;
  assign ERR_EVENT  = s_reg.err;

endmodule : qrd_top

// ---- qrd_pkg.sv ----
// Package of constants and types for the query response and display policy block
package qrd_pkg;

  // ==========================================================================
  // Register map (APB byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CMD      = 8'h00;
  localparam logic [7:0] ADDR_CTRL     = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_EVENT    = 8'h0c;
  localparam logic [7:0] ADDR_ALIAS    = 8'h10;
  localparam logic [7:0] ADDR_RESPONSE = 8'h14;

  // ==========================================================================
  // Command word fields (ADDR_CMD write)
  // ==========================================================================
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_ARG_LSB   = 4;
  localparam int CMD_PORT_BIT  = 8;
  localparam int CMD_EMPTY_BIT = 9;
  localparam int CMD_BAD_BIT   = 10;
  localparam int CMD_ALIAS_LSB = 16;

  // Control register fields
  localparam int CTRL_VERBOSE_BIT = 0;

  // Status register fields
  localparam int ST_POLICY_LSB   = 0;
  localparam int ST_HEADER_BIT   = 2;
  localparam int ST_PENDING_BIT  = 3;
  localparam int ST_LABELS_BIT   = 4;
  localparam int ST_BLANK_BIT    = 5;
  localparam int ST_KNOBTRK_BIT  = 6;
  localparam int ST_PANEL_BIT    = 7;
  localparam int ST_LOOP_BIT     = 8;
  localparam int ST_EOI_BIT      = 9;

  // Response format register fields
  localparam int RSP_HDR_BIT  = 0;
  localparam int RSP_LINK_BIT = 1;

  // ==========================================================================
  // Values
  // ==========================================================================
  localparam logic [8:0] EVT_UNDEFINED_ALIAS = 9'd271;
  localparam int         ALIAS_SLOTS         = 8;

  typedef enum logic [1:0] {
    POL_OFF   = 2'b00,
    POL_ON    = 2'b01,
    POL_NEVER = 2'b11
  } qrd_policy_t;

  typedef enum logic [3:0] {
    OP_NOP        = 4'h0,
    OP_SET        = 4'h1,
    OP_QUERY      = 4'h2,
    OP_FORCE_EOI  = 4'h3,
    OP_POLICY     = 4'h4,
    OP_HEADER     = 4'h5,
    OP_ALIAS_DEF  = 4'h6,
    OP_ALIAS_DEL  = 4'h7,
    OP_DEV_CLEAR  = 4'h8,
    OP_SET_DUMP   = 4'h9,
    OP_LIST_QUERY = 4'ha,
    OP_LOOP_START = 4'hb,
    OP_RSP_DONE   = 4'hc
  } qrd_op_t;

  localparam qrd_policy_t POLICY_RESET = POL_OFF;
  localparam logic        HEADER_RESET = 1'b1;

endpackage : qrd_pkg

// ---- qrd_top_properties.sv ----
// Concurrent checks of the command interpreter ports
`timescale 1ns/1ns
module qrd_top_checker
  import qrd_pkg::*;
(
  input wire logic        CLK,        // Clock
  input wire logic        RESETN,     // Reset
  input wire logic        PSEL,       // Select
  input wire logic        PENABLE,    // Enable
  input wire logic        PWRITE,     // Write
  input wire logic [7:0]  PADDR,      // Address
  input wire logic [31:0] PWDATA,     // Write data
  input wire logic [31:0] PRDATA,     // Read data
  input wire logic        PREADY,     // Ready
  input wire logic        PSLVERR,    // Bus error
  input wire logic        TEXT_WRITE, // Text in
  input wire logic        REFRESH,    // Refresh
  input wire logic        TEXT_SHOW,  // Text out
  input wire logic        EOI_OUT,    // Delimiter
  input wire logic        LABELS_ON,  // Labels
  input wire logic        MENU_BLANK, // Blank menu
  input wire logic        KNOB_TRACK, // Knob track
  input wire logic        ERR_EVENT   // Error pulse
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // ==========================================================================
  // Command decode and policy shadow
  logic        wr;
  logic [3:0]  op;
  logic [3:0]  arg;
  qrd_policy_t pol_reg;
  assign wr  = PSEL && PENABLE && PWRITE && (PADDR == ADDR_CMD);
  assign op  = PWDATA[3:0];
  assign arg = PWDATA[7:4];
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      pol_reg <= POL_OFF;
    end else if (wr && op == OP_POLICY) begin
      pol_reg <= (arg[1:0] == 2'h0) ? POL_OFF : (arg[1:0] == 2'h1) ? POL_ON : POL_NEVER;
    end
  end
  // ==========================================================================
  // Properties
  sequence s_cmd(qrd_policy_t p, qrd_op_t o); pol_reg == p && wr && op == o; endsequence
  sequence s_blank; !LABELS_ON && MENU_BLANK && !KNOB_TRACK; endsequence
  property p_bus_err; PSEL && PENABLE && PADDR > ADDR_RESPONSE |-> PSLVERR && PREADY; endproperty
  property p_eoi_cause; EOI_OUT |-> $past(wr && op == OP_FORCE_EOI); endproperty
  property p_err_cause; ERR_EVENT |-> $past(wr && op == OP_ALIAS_DEL); endproperty
  property p_on_set; s_cmd(POL_ON, OP_SET) ##0 !PWDATA[CMD_BAD_BIT] |-> ##[1:2] REFRESH; endproperty
  property p_off_clear; s_cmd(POL_OFF, OP_DEV_CLEAR) |-> ##[1:2] REFRESH; endproperty
  property p_off_bad; s_cmd(POL_OFF, OP_SET) ##0 PWDATA[CMD_BAD_BIT] |-> ##[1:2] REFRESH; endproperty
  property p_off_busy; s_cmd(POL_OFF, OP_SET) ##0 PWDATA[10:9] == 2'b00 |=> !REFRESH [*2]; endproperty
  property p_never_quiet; pol_reg == POL_NEVER && !wr |=> !REFRESH; endproperty
  property p_enter_never; wr && op == OP_POLICY && arg[1:0] >= 2'h2 |-> ##[1:2] s_blank; endproperty
  property p_leave_never; s_cmd(POL_NEVER, OP_POLICY) ##0 arg[1:0] < 2'h2 |-> ##[1:2] REFRESH;
  endproperty
  property p_text; TEXT_WRITE |=> TEXT_SHOW; endproperty
  property p_reset_view; $rose(RESETN) |-> LABELS_ON && KNOB_TRACK && !MENU_BLANK; endproperty
  a_bus_err: assert property (p_bus_err) else $error("no bus error");
  a_eoi_cause: assert property (p_eoi_cause) else $error("stray delimiter");
  a_err_cause: assert property (p_err_cause) else $error("stray error");
  a_on_set: assert property (p_on_set) else $error("no refresh after set");
  a_off_clear: assert property (p_off_clear) else $error("no refresh on clear");
  a_off_bad: assert property (p_off_bad) else $error("no refresh on bad command");
  a_off_busy: assert property (p_off_busy) else $error("refresh with input left");
  a_never_quiet: assert property (p_never_quiet) else $error("refresh in never");
  a_enter_never: assert property (p_enter_never) else $error("panel not blanked");
  a_leave_never: assert property (p_leave_never) else $error("no restore refresh");
  a_text: assert property (p_text) else $error("text not shown");
  a_reset_view: assert property (p_reset_view) else $error("bad panel at reset");
endmodule // qrd_top_checker

bind qrd_top qrd_top_checker chk_u (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
  .PRDATA, .PREADY, .PSLVERR, .TEXT_WRITE, .REFRESH, .TEXT_SHOW, .EOI_OUT, .LABELS_ON,
  .MENU_BLANK, .KNOB_TRACK, .ERR_EVENT);

// ---- qrd_host.sv ----
// Host controller model driving the register bus
`timescale 1ns/1ns
module qrd_host (
  input  wire logic        clk,     // Clock
  output logic             psel,    // Select
  output logic             penable, // Enable
  output logic             pwrite,  // Write
  output logic [7:0]       paddr,   // Address
  output logic [31:0]      pwdata,  // Write data
  input  wire logic [31:0] prdata,  // Read data
  input  wire logic        pready,  // Ready
  input  wire logic        pslverr  // Bus error
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // Released address and data are inverted so stale values never match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic t);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    t = (pready !== 1'b1);
    e = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // qrd_host

// ---- qrd_top_tb.sv ----
// Self-checking testbench of the command interpreter
`timescale 1ns/1ns
module qrd_top_tb
  import qrd_pkg::*;
;
  logic        CLK, RESETN, TEXT_WRITE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, rerr;
  logic        REFRESH, TEXT_SHOW, EOI_OUT, LABELS_ON, MENU_BLANK, KNOB_TRACK, ERR_EVENT;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  int          n_ref = 0, n_eoi = 0, n_err = 0, n_txt = 0, num_errors = 0, checks_done = 0;

  qrd_top dut_u (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .TEXT_WRITE, .REFRESH, .TEXT_SHOW, .EOI_OUT, .LABELS_ON, .MENU_BLANK,
    .KNOB_TRACK, .ERR_EVENT);
  qrd_host host_u (.clk(CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
    .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // Pulse counters
  always @(posedge CLK) begin
    n_ref <= n_ref + int'(REFRESH === 1'b1);
    n_eoi <= n_eoi + int'(EOI_OUT === 1'b1);
    n_err <= n_err + int'(ERR_EVENT === 1'b1);
    n_txt <= n_txt + int'(TEXT_SHOW === 1'b1);
  end
  // ==========================================================================
  // Helpers
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic t;
    host_u.xfer(w, a, d, rdata, rerr, t);
    if (t) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic st();
    acc(1'b0, ADDR_STATUS, 32'h0);
  endtask
  function automatic logic [31:0] cw(input qrd_op_t op, input logic [3:0] arg,
                                     input logic [2:0] flg = 3'b000, input logic [7:0] key = 8'h00);
    return {8'h00, key, 5'h00, flg, arg, op};
  endfunction
  // Issue a command and compare pulse counts; a negative count is not compared
  task automatic run(input logic [31:0] w, input int er, input int ee, input int ex);
    int r0, e0, x0;
    r0 = n_ref;
    e0 = n_eoi;
    x0 = n_err;
    acc(1'b1, ADDR_CMD, w);
    repeat (3) @(posedge CLK);
    if (er >= 0) chk(32'(n_ref - r0), 32'(er));
    if (ee >= 0) chk(32'(n_eoi - e0), 32'(ee));
    if (ex >= 0) chk(32'(n_err - x0), 32'(ex));
  endtask
  task automatic rsp(input qrd_op_t op, input logic port, input logic [31:0] exp);
    run(cw(op, 4'h0, {2'b00, port}), -1, 0, 0);
    acc(1'b0, ADDR_RESPONSE, 32'h0);
    chk(rdata & 32'h3, exp);
    run(cw(OP_RSP_DONE, 4'h0), -1, 0, 0);
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_basic();
    st();
    chk(rdata & 32'h1ff, 32'h054);
    acc(1'b0, 8'h40, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(rdata, 32'h0);
    run(cw(OP_ALIAS_DEF, 4'h0, 3'b000, 8'h21), -1, 0, 0);
    run(cw(OP_ALIAS_DEL, 4'h0, 3'b000, 8'h33), -1, 0, 1);
    acc(1'b0, ADDR_EVENT, 32'h0);
    chk(rdata, 32'(EVT_UNDEFINED_ALIAS));
    run(cw(OP_ALIAS_DEL, 4'h0, 3'b000, 8'h21), -1, 0, 0);
    run(cw(OP_FORCE_EOI, 4'h0), -1, 0, 0);
    run(cw(OP_QUERY, 4'h0), 0, 0, 0);
    st();
    chk(rdata & 32'h208, 32'h008);
    run(cw(OP_FORCE_EOI, 4'h0), -1, 1, 0);
    st();
    chk(rdata & 32'h208, 32'h200);
    run(cw(OP_RSP_DONE, 4'h0), -1, 0, 0);
  endtask
  task automatic t_off_on();
    run(cw(OP_SET, 4'h0), 0, 0, 0);
    run(cw(OP_SET, 4'h0, 3'b010), 1, 0, 0);
    rsp(OP_QUERY, 1'b0, 32'h3);
    run(cw(OP_SET, 4'h0, 3'b100), 1, 0, 0);
    run(cw(OP_QUERY, 4'h0, 3'b101), 1, 0, 0);
    run(cw(OP_DEV_CLEAR, 4'h0), 1, 0, 0);
    run(cw(OP_DEV_CLEAR, 4'h0, 3'b001), 1, 0, 0);
    run(cw(OP_POLICY, 4'h1), -1, 0, 0);
    st();
    chk(rdata & 32'h3, 32'h1);
    run(cw(OP_SET, 4'h0), 1, 0, 0);
  endtask
  task automatic t_never();
    int x;
    run(cw(OP_POLICY, 4'h2), -1, 0, 0);
    chk(32'({LABELS_ON, MENU_BLANK, KNOB_TRACK}), 32'h2);
    st();
    chk(rdata & 32'h3, 32'h3);
    run(cw(OP_SET, 4'h0, 3'b010), 0, 0, 0);
    run(cw(OP_SET, 4'h0, 3'b100), 0, 0, 0);
    run(cw(OP_DEV_CLEAR, 4'h0), 0, 0, 0);
    x = n_txt;
    TEXT_WRITE <= 1'b1;
    @(posedge CLK);
    TEXT_WRITE <= 1'b0;
    repeat (3) @(posedge CLK);
    chk(32'(n_txt - x), 32'h1);
    run(cw(OP_POLICY, 4'h0), 1, 0, 0);
    chk(32'({LABELS_ON, MENU_BLANK, KNOB_TRACK}), 32'h5);
    run(cw(OP_POLICY, 4'h3), -1, 0, 0);
    chk(32'({LABELS_ON, MENU_BLANK, KNOB_TRACK}), 32'h2);
    run(cw(OP_POLICY, 4'h1), 1, 0, 0);
    run(cw(OP_POLICY, 4'h0), -1, 0, 0);
  endtask
  task automatic t_header();
    run(cw(OP_HEADER, 4'h0), -1, 0, 0);
    st();
    chk(rdata & 32'h4, 32'h0);
    rsp(OP_QUERY, 1'b0, 32'h0);
    rsp(OP_SET_DUMP, 1'b0, 32'h3);
    rsp(OP_LIST_QUERY, 1'b0, 32'h2);
    acc(1'b1, ADDR_CTRL, 32'h1);
    rsp(OP_QUERY, 1'b1, 32'h3);
    rsp(OP_QUERY, 1'b0, 32'h0);
    acc(1'b1, ADDR_CTRL, 32'h0);
    run(cw(OP_HEADER, 4'h1), -1, 0, 0);
    rsp(OP_QUERY, 1'b0, 32'h3);
    run(cw(OP_LOOP_START, 4'h0, 3'b001), -1, 0, 0);
    st();
    chk(rdata & 32'h100, 32'h100);
    run(cw(OP_DEV_CLEAR, 4'h0, 3'b001), -1, 0, 0);
    st();
    chk(rdata & 32'h100, 32'h0);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    RESETN = 1'b0;
    TEXT_WRITE = 1'b0;
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    t_basic();
    t_off_on();
    t_never();
    t_header();
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge CLK);
    num_errors++;
    report_and_stop();
  end
endmodule // qrd_top_tb
